// [pkg/mms_pkg.sv]
// Shared constants, carriers and state layout for the module management select and paging block.
package mms_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_RESET_INIT_NS = 10000;
    localparam int RESET_INIT_CYC = (T_RESET_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CW = $clog2(RESET_INIT_CYC + 1);

    localparam logic [6:0] TW_DEV_ADDR = 7'h50;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_BANK_SEL = 8'h7e;
    localparam logic [7:0] ADDR_PAGE_SEL = 8'h7f;
    localparam logic [7:0] PAGE_00 = 8'h00;
    localparam logic [7:0] PAGE_01 = 8'h01;
    localparam logic [7:0] PAGE_02 = 8'h02;
    localparam logic [7:0] PAGE_10 = 8'h10;
    localparam logic [7:0] PAGE_11 = 8'h11;
    localparam logic [7:0] NUM_BANKS = 8'h02;
    localparam int MEM_AW = 10;

    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_SEL = 2;
    localparam int PIN_RST = 3;
    localparam int PIN_LP = 4;
    localparam int PIN_IRQ = 5;
    localparam int NPIN = 6;
    localparam logic [NPIN-1:0] PIN_IDLE = 6'h3f;

    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_MASK = 12'h008;
    localparam logic [11:0] REG_FLAG_SET = 12'h00c;
    localparam logic [11:0] REG_STATE = 12'h010;
    localparam logic [11:0] REG_MEM_ADDR = 12'h014;
    localparam logic [11:0] REG_MEM_DATA = 12'h018;
    localparam int ST_HOST_WR = 0;
    localparam int ST_RESET = 1;
    localparam int ST_LOW_POWER_REQUEST = 2;
    localparam int ST_FLAGS_READ = 3;
    localparam int ST_W = 4;
    localparam logic CTRL_EN_RESET = 1'b1;

    typedef enum logic [2:0] {
        TW_IDLE, TW_ADDR, TW_ADDR_ACK, TW_WRITE, TW_WRITE_ACK, TW_READ, TW_READ_ACK
    } mms_tw_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
    } mms_ahb_req_t;

    typedef struct packed {
        logic [MEM_AW-1:0] addr;
        logic we;
        logic [7:0] wdata;
    } mms_mem_port_t;

    typedef struct packed {
        logic hit;
        logic [MEM_AW-1:0] idx;
    } mms_map_t;

    typedef struct packed {
        logic [NPIN-1:0] s1;
        logic [NPIN-1:0] s2;
        logic [NPIN-1:0] s3;
        logic [NPIN-1:0] pf;
        mms_tw_state_t tw;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic rw;
        logic first;
        logic [7:0] pointer;
        logic [7:0] page;
        logic [7:0] bank;
        logic [7:0] flags;
        logic sda_drive;
        logic [RST_CW-1:0] rst_cnt;
        logic rst_done;
        logic ctrl_en;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [MEM_AW-1:0] mem_addr;
        mms_ahb_req_t req;
        logic [31:0] hrdata;
    } mms_state_t;

    localparam mms_state_t MMS_RESET = '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, pf: PIN_IDLE,
        tw: TW_IDLE, ctrl_en: CTRL_EN_RESET, default: '0};

    // Lower half is slot 0; each implemented page or bank instance owns one 128-byte slot.
    function automatic mms_map_t mms_map(input logic [7:0] addr, input logic [7:0] page,
                                         input logic [7:0] bank);
        mms_map_t m;
        logic [2:0] slot;
        slot = 3'h0;
        m.hit = 1'b1;
        if (addr[7]) begin
            case (page)
                PAGE_00: slot = 3'h1;
                PAGE_01: slot = 3'h2;
                PAGE_02: slot = 3'h3;
                PAGE_10: slot = (bank == 8'h00) ? 3'h4 : 3'h6;
                PAGE_11: slot = (bank == 8'h00) ? 3'h5 : 3'h7;
                default: m.hit = 1'b0;
            endcase
            if ((page == PAGE_10 || page == PAGE_11) && bank >= NUM_BANKS) begin
                m.hit = 1'b0;
            end
        end
        m.idx = {slot, addr[6:0]};
        return m;
    endfunction
endpackage

// [hw/mms_mem.sv]
// Two-port byte memory holding the lower half and every implemented page slot.
`timescale 1ns/100ps
module mms_mem import mms_pkg::*; (
    input wire logic core_clk,
    input wire mms_mem_port_t port_a,
    input wire mms_mem_port_t port_b,
    output logic [7:0] rdata_a,
    output logic [7:0] rdata_b
);
    logic [7:0] mem [0:(1<<MEM_AW)-1];

    // A same-address write from both ports in one cycle keeps the software value.
    always_ff @(posedge core_clk) begin
        if (port_a.we) begin
            mem[port_a.addr] <= port_a.wdata;
        end
        if (port_b.we) begin
            mem[port_b.addr] <= port_b.wdata;
        end
        rdata_a <= mem[port_a.addr];
        rdata_b <= mem[port_b.addr];
    end
endmodule

// [hw/mms_top.sv]
// Management select, reset, power, presence, interrupt and paged memory access of the module.
`timescale 1ns/100ps
// What this block does
// - Answer management bus only while selected low
// - Deselected module never acknowledges any transfer
// - Long low reset pin restores default settings
// - Low-power pin level steers power mode
// - Presence output tied low, host pulls up
// - Interrupt pin pulled low on flagged event
// - Interrupt released after all flags read
// - 256-byte space, lower and upper halves
// - One selected 128-byte page in upper half
// - Bank selects instance of banked pages
// - Lower half visible whatever page selected
// - Lower half and page 00h always implemented
// - Pages 01h, 02h, banks 0 and 1 of 10h, 11h
// - Banks of pages 10h-1Fh cover lane groups
module mms_top import mms_pkg::*; (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_request,
    output logic module_present_n,
    input wire logic module_irq_n_i,
    output logic module_irq_n_o,
    output logic module_irq_oe_n,
    output logic low_power_mode,
    output logic settings_reset
);
    mms_state_t r;
    mms_state_t n;
    mms_map_t tw_map;
    mms_mem_port_t mem_a;
    mms_mem_port_t mem_b;
    logic [7:0] rdata_a;
    logic [7:0] rdata_b;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic selected;
    logic soft_rst;
    logic do_load;
    logic flag_rd_ld;
    logic tw_commit;
    logic ahb_take;
    logic [7:0] flag_set;
    logic [7:0] load_byte;

    mms_mem u_mem (
        .core_clk(core_clk),
        .port_a(mem_a),
        .port_b(mem_b),
        .rdata_a(rdata_a),
        .rdata_b(rdata_b)
    );

    always_comb begin
        n = r;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        soft_rst = 1'b0;
        do_load = 1'b0;
        flag_rd_ld = 1'b0;
        tw_commit = 1'b0;
        flag_set = 8'h00;
        load_byte = 8'h00;
        tw_map = mms_map(r.pointer, r.page, r.bank);
        mem_a = '{addr: tw_map.idx, we: 1'b0, wdata: r.shift};
        mem_b = '{addr: r.mem_addr, we: 1'b0, wdata: hwdata[7:0]};

        // Pins settle only when the second and third stages agree, which rejects single-sample glitches.
        n.s1 = {module_irq_n_i, low_power_request, module_reset_n, module_select_n, sda_i, scl};
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.pf = ((r.s2 ~^ r.s3) & r.s3) | (~(r.s2 ~^ r.s3) & r.pf);
        scl_rise = ~r.pf[PIN_SCL] & n.pf[PIN_SCL];
        scl_fall = r.pf[PIN_SCL] & ~n.pf[PIN_SCL];
        start = r.pf[PIN_SCL] & n.pf[PIN_SCL] & r.pf[PIN_SDA] & ~n.pf[PIN_SDA];
        stop = r.pf[PIN_SCL] & n.pf[PIN_SCL] & ~r.pf[PIN_SDA] & n.pf[PIN_SDA];
        selected = ~n.pf[PIN_SEL] & r.ctrl_en;

        // Bus data phase; write-one-to-clear is applied before any event so that a set wins.
        ahb_take = hsel & htrans[1] & hready;
        if (r.req.valid && r.req.write) begin
            case (r.req.addr)
                REG_CTRL: n.ctrl_en = hwdata[0];
                REG_STATUS: n.status = r.status & ~hwdata[ST_W-1:0];
                REG_MASK: n.mask = hwdata[ST_W-1:0];
                REG_FLAG_SET: flag_set = hwdata[7:0];
                REG_MEM_ADDR: begin
                    n.mem_addr = hwdata[MEM_AW-1:0];
                    mem_b.addr = hwdata[MEM_AW-1:0];
                end
                REG_MEM_DATA: mem_b.we = 1'b1;
                default: ;
            endcase
        end
        n.req = '{valid: ahb_take, write: hwrite, addr: haddr[11:0]};
        if (ahb_take && !hwrite) begin
            case (haddr[11:0])
                REG_CTRL: n.hrdata = 32'({r.ctrl_en});
                REG_STATUS: n.hrdata = 32'(r.status);
                REG_MASK: n.hrdata = 32'(r.mask);
                REG_FLAG_SET: n.hrdata = 32'(r.flags);
                REG_STATE: n.hrdata = 32'({r.tw, r.pf[PIN_IRQ], ~r.pf[PIN_RST], ~r.pf[PIN_SEL],
                                           r.pf[PIN_LP], r.bank, r.page});
                REG_MEM_ADDR: n.hrdata = 32'(r.mem_addr);
                REG_MEM_DATA: n.hrdata = 32'(rdata_b);
                default: n.hrdata = 32'h0000_0000;
            endcase
        end

        if (r.pf[PIN_RST]) begin
            n.rst_cnt = '0;
            n.rst_done = 1'b0;
        end else if (!r.rst_done) begin
            if (r.rst_cnt == RST_CW'(RESET_INIT_CYC)) begin
                soft_rst = 1'b1;
                n.rst_done = 1'b1;
            end else begin
                n.rst_cnt = r.rst_cnt + 1'b1;
            end
        end

        if (!selected || stop) begin
            n.tw = TW_IDLE;
            n.sda_drive = 1'b0;
        end else if (start) begin
            n.tw = TW_ADDR;
            n.bit_cnt = 4'h0;
            n.sda_drive = 1'b0;
        end else begin
            case (r.tw)
                TW_ADDR, TW_WRITE: begin
                    if (scl_rise) begin
                        n.shift = {r.shift[6:0], n.pf[PIN_SDA]};
                        n.bit_cnt = r.bit_cnt + 4'h1;
                    end else if (scl_fall && r.bit_cnt == 4'h8) begin
                        if (r.tw == TW_ADDR) begin
                            if (r.shift[7:1] == TW_DEV_ADDR) begin
                                n.sda_drive = 1'b1;
                                n.rw = r.shift[0];
                                n.tw = TW_ADDR_ACK;
                            end else begin
                                n.tw = TW_IDLE;
                            end
                        end else begin
                            n.sda_drive = 1'b1;
                            n.tw = TW_WRITE_ACK;
                            tw_commit = 1'b1;
                            n.first = 1'b0;
                            if (r.first) begin
                                n.pointer = r.shift;
                            end else begin
                                // page and bank writes steer later accesses
                                mem_a.we = tw_map.hit;
                                n.pointer = r.pointer + 8'h01;
                                n.status[ST_HOST_WR] = 1'b1;
                                if (r.pointer == ADDR_PAGE_SEL) begin
                                    n.page = r.shift;
                                end
                                if (r.pointer == ADDR_BANK_SEL) begin
                                    n.bank = r.shift;
                                end
                            end
                        end
                    end
                end
                TW_ADDR_ACK, TW_WRITE_ACK: begin
                    if (scl_fall) begin
                        n.bit_cnt = 4'h0;
                        if (r.tw == TW_ADDR_ACK && r.rw) begin
                            do_load = 1'b1;
                        end else begin
                            n.sda_drive = 1'b0;
                            n.tw = TW_WRITE;
                            if (r.tw == TW_ADDR_ACK) begin
                                n.first = 1'b1;
                            end
                        end
                    end
                end
                TW_READ: begin
                    if (scl_fall) begin
                        if (r.bit_cnt == 4'h7) begin
                            n.sda_drive = 1'b0;
                            n.tw = TW_READ_ACK;
                        end else begin
                            n.shift = {r.shift[6:0], 1'b0};
                            n.sda_drive = ~r.shift[6];
                            n.bit_cnt = r.bit_cnt + 4'h1;
                        end
                    end
                end
                TW_READ_ACK: begin
                    if (scl_rise && n.pf[PIN_SDA]) begin
                        n.tw = TW_IDLE;
                    end else if (scl_fall) begin
                        do_load = 1'b1;
                    end
                end
                default: n.tw = TW_IDLE;
            endcase
        end

        // lower half outside the flags, bank and page bytes served from slot 0 regardless of page
        if (r.pointer == ADDR_FLAGS) begin
            load_byte = r.flags;
        end else if (r.pointer == ADDR_PAGE_SEL) begin
            load_byte = r.page;
        end else if (r.pointer == ADDR_BANK_SEL) begin
            load_byte = r.bank;
        end else if (tw_map.hit) begin
            load_byte = rdata_a;
        end
        if (do_load) begin
            n.shift = load_byte;
            n.sda_drive = ~load_byte[7];
            n.bit_cnt = 4'h0;
            n.tw = TW_READ;
            n.pointer = r.pointer + 8'h01;
            flag_rd_ld = (r.pointer == ADDR_FLAGS);
        end

        // flags clear when read or on a long reset, a new set wins over a read
        n.flags = (r.flags & ~(flag_rd_ld ? r.flags : 8'h00)) | flag_set;
        if (flag_rd_ld && r.flags != 8'h00) begin
            n.status[ST_FLAGS_READ] = 1'b1;
        end
        if (n.pf[PIN_LP] != r.pf[PIN_LP]) begin
            n.status[ST_LOW_POWER_REQUEST] = 1'b1;
        end
        if (soft_rst) begin
            n.page = PAGE_00;
            n.bank = 8'h00;
            n.flags = 8'h00;
            n.pointer = 8'h00;
            n.tw = TW_IDLE;
            n.sda_drive = 1'b0;
            n.status[ST_RESET] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r <= MMS_RESET;
        end else begin
            r <= n;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.hrdata;
    assign irq = |(r.status & r.mask);
    assign sda_o = 1'b0;
    assign sda_oe_n = ~r.sda_drive;
    assign module_present_n = 1'b0;
    assign module_irq_n_o = 1'b0;
    assign module_irq_oe_n = ~(|r.flags);
    assign low_power_mode = r.pf[PIN_LP];
    // High from a completed long reset until the reset pin is released.
    assign settings_reset = r.rst_done;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_long_reset;
        soft_rst;
    endsequence
    sequence s_defaults;
        r.page == PAGE_00 && r.bank == 8'h00 && r.flags == 8'h00 && r.status[ST_RESET];
    endsequence
    property p_reset_defaults;
        s_long_reset |=> s_defaults;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("defaults not restored");
    property p_reset_len;
        soft_rst |-> !r.pf[PIN_RST] && r.rst_cnt == RST_CW'(RESET_INIT_CYC) && !r.rst_done;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset fired early");
    property p_desel_release;
        r.pf[PIN_SEL] |=> !r.sda_drive && r.tw == TW_IDLE;
    endproperty
    a_desel_release: assert property (p_desel_release) else $error("deselected module drives data");
    property p_desel_no_start;
        (r.tw == TW_IDLE && r.pf[PIN_SEL] && n.pf[PIN_SEL]) |=> r.tw == TW_IDLE;
    endproperty
    a_desel_no_start: assert property (p_desel_no_start) else $error("transfer begun while deselected");
    property p_lp_event;
        $changed(r.pf[PIN_LP]) |-> r.status[ST_LOW_POWER_REQUEST] && low_power_mode == r.pf[PIN_LP];
    endproperty
    a_lp_event: assert property (p_lp_event) else $error("power mode change not seen");
    property p_irq_pin;
        module_irq_oe_n == (r.flags == 8'h00) && module_irq_n_o == 1'b0;
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not tied to flags");
    property p_flags_hold;
        (r.flags != 8'h00 && !flag_rd_ld && !soft_rst) |=> (r.flags & $past(r.flags)) == $past(r.flags);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flag lost without read");
    property p_page_sel;
        (tw_commit && !r.first && r.pointer == ADDR_PAGE_SEL) |=> r.page == $past(r.shift);
    endproperty
    a_page_sel: assert property (p_page_sel) else $error("page select ignored");
    property p_lower_map;
        !r.pointer[7] |-> tw_map.hit && tw_map.idx[MEM_AW-1:7] == 3'h0;
    endproperty
    a_lower_map: assert property (p_lower_map) else $error("lower half remapped");
    property p_bank_map;
        (r.pointer[7] && r.page == PAGE_10 && r.bank == 8'h01) |-> tw_map.hit && tw_map.idx[MEM_AW-1:7] == 3'h6;
    endproperty
    a_bank_map: assert property (p_bank_map) else $error("bank instance not selected");
    property p_present;
        module_present_n == 1'b0;
    endproperty
    a_present: assert property (p_present) else $error("presence not asserted");
endmodule

// [verification/mms_host_model.sv]
// Host-side model of the shared 2-wire management bus and of the select pin.
`timescale 1ns/100ps
module mms_host_model #(
    parameter int T_SEL_NS = 2000
) (
    output logic scl,
    output logic sda_h,
    output logic sel_n,
    input wire logic sda,
    output logic [7:0] rx_byte,
    output logic rx_tgl
);
    int stretch = 0;
    logic r;
    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
        sel_n = 1'b1;
        rx_byte = 8'h00;
        rx_tgl = 1'b0;
    end
    // Select settle wait.
    // Only one module hangs on this bus, so the waits of different modules never need to overlap.
    task automatic select(input logic on);
        #13 sel_n = !on;
        #(T_SEL_NS);
    endtask
    // The clock stands high between frames, and a released data line reads high through its pull-up.
    task automatic bit_io(input logic b, output logic q);
        #100 sda_h = b;
        #100 scl = 1'b1;
        #100 q = sda;
        #100 scl = 1'b0;
    endtask
    // The odd offset keeps every line change away from the core clock edges.
    task automatic start();
        #213 sda_h = 1'b0;
        #200 scl = 1'b0;
    endtask
    task automatic stop();
        #100 sda_h = 1'b0;
        #100 scl = 1'b1;
        #200 sda_h = 1'b1;
        #200;
    endtask
    // A slow host idles with the clock low before each byte it writes.
    task automatic wr(input logic [7:0] b, output logic ack_n);
        #(stretch);
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, ack_n);
    endtask
    task automatic rd(input logic last);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, rx_byte[i]);
        bit_io(last, r);
        rx_tgl = !rx_tgl;
    endtask
endmodule

// [verification/tb_mms_top.sv]
// Self-checking bench for the management select, paging and interrupt block.
`timescale 1ns/100ps
module tb_mms_top import mms_pkg::*; ;
    logic core_clk, resetn, hsel, hwrite, rst_pin_n, lp_req, rd_ph, set_rst;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic hreadyout, hresp, irq, sda_o, sda_oe_n, present_n, irq_o, irq_oe_n, lp_mode, scl, sda_h, sel_n, rx_tgl;
    logic [7:0] rx_byte;
    logic [63:0] aq[$];
    logic [63:0] e;
    logic [7:0] lq[$];
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    // Open-drain lines read high through their pull-ups unless some party pulls low.
    wire sda = sda_h & (sda_oe_n | sda_o);
    wire irq_line = irq_oe_n | irq_o;
    mms_top mms_top_i (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .irq(irq), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .module_select_n(sel_n), .module_reset_n(rst_pin_n), .low_power_request(lp_req),
        .module_present_n(present_n), .module_irq_n_i(irq_line), .module_irq_n_o(irq_o),
        .module_irq_oe_n(irq_oe_n), .low_power_mode(lp_mode), .settings_reset(set_rst));
    mms_host_model mms_host_model_i (.scl(scl), .sda_h(sda_h), .sel_n(sel_n), .sda(sda), .rx_byte(rx_byte),
        .rx_tgl(rx_tgl));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp, input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_ph <= !w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd_ph <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        aq.push_back({m, v});
        ahb(1'b0, a, 32'h0);
    endtask
    task automatic tw_wr(input logic [7:0] p, input logic [7:0] b0, input logic [7:0] b1, input int n,
                         input logic nack);
        logic a;
        mms_host_model_i.start();
        mms_host_model_i.wr({TW_DEV_ADDR, 1'b0}, a);
        chk_pin(a, nack, "address ack");
        if (!nack) begin
            mms_host_model_i.wr(p, a);
            if (n > 0) mms_host_model_i.wr(b0, a);
            if (n > 1) mms_host_model_i.wr(b1, a);
        end
        mms_host_model_i.stop();
    endtask
    task automatic tw_rd(input logic [7:0] p, input logic [7:0] x);
        logic a;
        tw_wr(p, 8'h00, 8'h00, 0, 1'b0);
        lq.push_back(x);
        mms_host_model_i.start();
        mms_host_model_i.wr({TW_DEV_ADDR, 1'b1}, a);
        mms_host_model_i.rd(1'b1);
        mms_host_model_i.stop();
    endtask
    always @(posedge core_clk) begin
        if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
            e = aq.pop_front();
            chk_word(hrdata & e[63:32], e[31:0], "bus read");
            chk_pin(hresp, 1'b0, "bus response");
        end
    end
    always @(rx_tgl) begin
        if (lq.size() > 0) chk_word({24'h0, rx_byte}, {24'h0, lq.pop_front()}, "link read");
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        logic [7:0] v [8];
        logic [7:0] lo;
        logic [7:0] pg [8] = '{8'h03, 8'h00, 8'h01, 8'h02, 8'h10, 8'h10, 8'h10, 8'h11};
        logic [7:0] bk [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
        logic [2:0] sl [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h0, 3'h5};
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rd_ph = 1'b0;
        resetn = 1'b0;
        rst_pin_n = 1'b1;
        lp_req = 1'b1;
        void'($urandom(25));
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        cyc(1);
        chk_pin(irq_oe_n, 1'b1, "interrupt pin");
        chk_pin(lp_mode, 1'b1, "power mode");
        chk_pin(present_n, 1'b0, "presence");
        rd(REG_CTRL, 32'h1, 32'h1);
        rd(12'h020, 32'hffffffff, 32'h0);
        lo = 8'($urandom());
        ahb(1'b1, REG_MEM_ADDR, 32'h10);
        ahb(1'b1, REG_MEM_DATA, {24'h0, lo});
        for (int i = 0; i < 8; i++) begin
            v[i] = (sl[i] != 3'h0) ? 8'($urandom()) : 8'h00;
            ahb(1'b1, REG_MEM_ADDR, {22'h0, sl[i], 7'h10});
            if (sl[i] != 3'h0) ahb(1'b1, REG_MEM_DATA, {24'h0, v[i]});
        end
        mms_host_model_i.select(1'b1);
        for (int i = 0; i < 8; i++) begin
            mms_host_model_i.stretch = (i == 4) ? 3000 : 0;
            tw_wr(ADDR_BANK_SEL, bk[i], pg[i], 2, 1'b0);
            rd(REG_STATE, 32'hffff, {16'h0, bk[i], pg[i]});
            tw_rd(8'h90, v[i]);
            tw_rd(8'h10, lo);
        end
        tw_wr(8'h90, ~v[7], 8'h00, 1, 1'b0);
        ahb(1'b1, REG_MEM_ADDR, {22'h0, sl[7], 7'h10});
        rd(REG_MEM_DATA, 32'hff, {24'h0, ~v[7]});
        mms_host_model_i.select(1'b0);
        tw_wr(8'h00, 8'h00, 8'h00, 0, 1'b1);
        mms_host_model_i.select(1'b1);
        ahb(1'b1, REG_CTRL, 32'h0);
        tw_wr(8'h00, 8'h00, 8'h00, 0, 1'b1);
        ahb(1'b1, REG_CTRL, 32'h1);
        ahb(1'b1, REG_FLAG_SET, 32'h5);
        cyc(3);
        chk_pin(irq_line, 1'b0, "interrupt pin");
        tw_rd(ADDR_FLAGS, 8'h05);
        cyc(3);
        chk_pin(irq_line, 1'b1, "interrupt pin");
        rd(REG_STATUS, 32'h9, 32'h9);
        ahb(1'b1, REG_MASK, 32'h8);
        cyc(3);
        chk_pin(irq, 1'b1, "irq");
        ahb(1'b1, REG_STATUS, 32'h8);
        cyc(3);
        chk_pin(irq, 1'b0, "irq");
        @(posedge core_clk);
        lp_req <= 1'b0;
        cyc(6);
        chk_pin(lp_mode, 1'b0, "power mode");
        rd(REG_STATUS, 32'h4, 32'h4);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            rst_pin_n <= 1'b0;
            cyc((k == 1) ? RESET_INIT_CYC + 20 : RESET_INIT_CYC - 20);
            chk_pin(set_rst, k == 1, "settings reset");
            @(posedge core_clk);
            rst_pin_n <= 1'b1;
            cyc(6);
            chk_pin(set_rst, 1'b0, "settings reset");
            rd(REG_STATE, 32'hff, (k == 1) ? 32'h0 : 32'h11);
            rd(REG_STATUS, 32'h2, (k == 1) ? 32'h2 : 32'h0);
        end
        cyc(2);
        stop_test();
    end
endmodule
